// *** board_io_expander.v ***
// line expander: forty lines (eighteen host-configurable), two edge interrupts,
// three converter result slots, two-wire target and a register port
// assumes one 25 MHz clock; pins are asynchronous to it
`timescale 1ns/1ps
`default_nettype none
`include "io_expander_consts.vh"

// Summary of operation
// - configuration and status travel over two-wire bus; two attention lines.
// - lines outside the fixed masks are host-set input or output, no pulls.
// - each interrupt input picks rising, falling or both edges.
// - enabled interrupt firing records status and asserts attention.
// - any enabled interrupt wakes the system from suspend or off.
// - converter channel index equals its sampled line index.
// - results are 12-bit unsigned, right-justified, supply referenced.
// - lines 3-5 digital/converter, 37 and 32 interrupt, 6 digital.
// - power-domain lines are outputs enabling peripheral rails.
// - one standby output places both transceivers in standby.
// - indicator set by configuring its line as output and level.
// - radio reset, sleep request, awake status and commission lines.
// - camera powerdown on line 22, bidirectional line 31.
// - serializer gets order-reverse and clock-edge-select outputs.
// - target answers at address 0x6e, 100 kbit/s.
module board_io_expander #(
  parameter NLINES = 40,
  parameter NADC = 3,
  parameter [6:0] TARGET_ADDR = `TARGET_ADDR
) (
  input wire clk,
  input wire rst,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe_n,
  input wire [NLINES-1:0] line_in,
  output wire [NLINES-1:0] line_out,
  output wire [NLINES-1:0] line_oe_n,
  input wire [NADC*`ADC_BITS-1:0] adc_code,
  input wire [NADC-1:0] adc_valid,
  output wire irq,
  output wire wake_req,
  output wire micro_attention_irq_n,
  output wire cpu_attention_irq_n
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg [NLINES-1:0] dir_q;
  reg [NLINES-1:0] out_q;
  reg [1:0] stat_q;
  reg [1:0] mask_q;
  reg [3:0] edge_q;
  reg [NADC-1:0] amode_q;
  reg [NADC*`ADC_BITS-1:0] adc_q;
  reg [1:0] stat_d;
  reg [31:0] rdata_d;

  wire [NLINES-1:0] lvl;
  wire [NLINES-1:0] lrise;
  wire [NLINES-1:0] lfall;
  wire [1:0] bus_lvl;
  wire [1:0] bus_rise;
  wire [1:0] bus_fall;
  wire [7:0] t_ptr;
  wire [31:0] t_wdata;
  wire t_wr;
  wire t_rd;
  wire plain;
  wire acc_wr;
  wire acc_rd;
  wire [7:0] acc_addr;
  wire [31:0] acc_wdata;
  wire [NLINES-1:0] amask;
  wire [NLINES-1:0] drive;
  wire [1:0] ev;
  integer i;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // low word of a line vector; hi_word below pads its upper part with zeros
  function [31:0] lo_word;
    input [NLINES-1:0] v;
    begin
      lo_word = v[31:0];
    end
  endfunction

  function [31:0] hi_word;
    input [NLINES-1:0] v;
    reg [63:0] t;
    begin
      t = 64'h0;
      t[NLINES-1:0] = v;
      hi_word = t[63:32];
    end
  endfunction

  // configured-edge match for one interrupt source
  function edge_hit;
    input [1:0] cfg;
    input r;
    input f;
    begin
      edge_hit = (cfg[`EDGE_RISE_BIT] & r) | (cfg[`EDGE_FALL_BIT] & f);
    end
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  sync_filter #(.W(NLINES)) u_line_sync (
    .clk(clk),
    .rst(rst),
    .d(line_in),
    .q_q(lvl),
    .rise_q(lrise),
    .fall_q(lfall)
  );

  sync_filter #(.W(2)) u_bus_sync (
    .clk(clk),
    .rst(rst),
    .d({sda_in, scl_in}),
    .q_q(bus_lvl),
    .rise_q(bus_rise),
    .fall_q(bus_fall)
  );

  // ----------------------------------------------------------------
  // two-wire target
  // ----------------------------------------------------------------
  twowire_target #(.ADDR(TARGET_ADDR)) u_target (
    .clk(clk),
    .rst(rst),
    .scl(bus_lvl[0]),
    .sda(bus_lvl[1]),
    .scl_rise(bus_rise[0]),
    .scl_fall(bus_fall[0]),
    .sda_rise(bus_rise[1]),
    .sda_fall(bus_fall[1]),
    .sda_oe_n(sda_oe_n),
    .ptr_q(t_ptr),
    .wbuf_q(t_wdata),
    .wr_q(t_wr),
    .rd_q(t_rd),
    .rdata(reg_rdata)
  );

  // open drain: only ever pulls low
  assign sda_out = 1'b0;

  // the plain port wins a same-cycle clash; the bus is far slower
  assign plain = reg_wr | reg_rd;
  assign acc_wr = reg_wr | (t_wr & ~plain);
  assign acc_rd = reg_rd | (t_rd & ~plain);
  assign acc_addr = plain ? reg_addr : t_ptr;
  assign acc_wdata = plain ? reg_wdata : t_wdata;

  // ----------------------------------------------------------------
  // line drivers
  // ----------------------------------------------------------------
  // converter lines 3..5 float while in analog mode
  assign amask = {{(NLINES-NADC-`ADC_FIRST_CH){1'b0}}, amode_q,
                  {`ADC_FIRST_CH{1'b0}}};
  // rails, standby, radio, camera and serializer controls are
  // always driven; the radio status line is never driven
  assign drive = (dir_q | `FIXED_OUT_MASK) & ~`FIXED_IN_MASK
                 & ~amask;
  assign line_oe_n = ~drive;
  assign line_out = out_q;

  // ----------------------------------------------------------------
  // interrupt events and attention
  // ----------------------------------------------------------------
  assign ev[0] = edge_hit(edge_q[1:0], lrise[`IRQ_LINE_A],
                          lfall[`IRQ_LINE_A]);
  assign ev[1] = edge_hit(edge_q[3:2], lrise[`IRQ_LINE_B],
                          lfall[`IRQ_LINE_B]);

  assign irq = |(stat_q & mask_q);
  // no internal power states: a pending unmasked source always asks for wake
  assign wake_req = irq;
  assign micro_attention_irq_n = ~irq;
  assign cpu_attention_irq_n = ~irq;

  // a new event beats a write-one-to-clear in the same cycle
  always @* begin
    stat_d = stat_q;
    if (acc_wr && acc_addr == `OFS_IRQ_STAT) begin
      stat_d = stat_d & ~acc_wdata[1:0];
    end
    stat_d = stat_d | ev;
  end

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      dir_q <= `RST_DIR;
      out_q <= `RST_OUT;
      stat_q <= 2'h0;
      mask_q <= `RST_IRQ_MASK;
      edge_q <= `RST_IRQ_EDGE;
      amode_q <= `RST_ADC_MODE;
    end else begin
      stat_q <= stat_d;
      if (acc_wr) begin
        case (acc_addr)
          `OFS_DIR_LO: dir_q[31:0] <= acc_wdata;
          `OFS_DIR_HI: dir_q[NLINES-1:32] <= acc_wdata[NLINES-33:0];
          `OFS_OUT_LO: out_q[31:0] <= acc_wdata;
          `OFS_OUT_HI: out_q[NLINES-1:32] <= acc_wdata[NLINES-33:0];
          `OFS_IRQ_MASK: mask_q <= acc_wdata[1:0];
          `OFS_IRQ_EDGE: edge_q <= acc_wdata[3:0];
          `OFS_ADC_MODE: amode_q <= acc_wdata[NADC-1:0];
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // converter results
  // ----------------------------------------------------------------
  // results are taken only while the line is in analog mode
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      adc_q <= {(NADC*`ADC_BITS){1'b0}};
    end else begin
      for (i = 0; i < NADC; i = i + 1) begin
        if (adc_valid[i] && amode_q[i]) begin
          adc_q[i*`ADC_BITS +: `ADC_BITS] <=
            adc_code[i*`ADC_BITS +: `ADC_BITS];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------
  always @* begin
    rdata_d = 32'h0000_0000;
    case (acc_addr)
      `OFS_DIR_LO: rdata_d = lo_word(drive);
      `OFS_DIR_HI: rdata_d = hi_word(drive);
      `OFS_OUT_LO: rdata_d = lo_word(out_q);
      `OFS_OUT_HI: rdata_d = hi_word(out_q);
      `OFS_IN_LO: rdata_d = lo_word(lvl);
      `OFS_IN_HI: rdata_d = hi_word(lvl);
      `OFS_IRQ_STAT: rdata_d = {30'h0, stat_q};
      `OFS_IRQ_MASK: rdata_d = {30'h0, mask_q};
      `OFS_IRQ_EDGE: rdata_d = {28'h0, edge_q};
      `OFS_ADC_MODE: rdata_d[NADC-1:0] = amode_q;
      default: begin
        // slot for channel n sits at base + 4 * n
        for (i = 0; i < NADC; i = i + 1) begin
          if (acc_addr == `OFS_ADC_BASE
              + {i[5:0] + 6'd `ADC_FIRST_CH, 2'b00}) begin
            rdata_d[`ADC_BITS-1:0] =
              adc_q[i*`ADC_BITS +: `ADC_BITS];
          end
        end
      end
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (acc_rd) begin
      reg_rdata <= rdata_d;
    end
  end

endmodule

`default_nettype wire

// *** io_expander_consts.vh ***
// constants shared by the line expander design files
// assumes byte addresses on a 32-bit register port; definitions only
`ifndef IO_EXPANDER_CONSTS_VH
`define IO_EXPANDER_CONSTS_VH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define OFS_DIR_LO 8'h00
`define OFS_DIR_HI 8'h04
`define OFS_OUT_LO 8'h08
`define OFS_OUT_HI 8'h0c
`define OFS_IN_LO 8'h10
`define OFS_IN_HI 8'h14
`define OFS_IRQ_STAT 8'h18
`define OFS_IRQ_MASK 8'h1c
`define OFS_IRQ_EDGE 8'h20
`define OFS_ADC_MODE 8'h24
`define OFS_ADC_BASE 8'h40

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_DIR 40'h00_0000_0000
`define RST_OUT 40'h00_0000_0000
`define RST_IRQ_MASK 2'h0
`define RST_IRQ_EDGE 4'h0
`define RST_ADC_MODE 3'h0

// ----------------------------------------------------------------
// line map
// ----------------------------------------------------------------
// rails, standby, radio, camera powerdown, serializer options
`define FIXED_OUT_MASK 40'h46_7c66_f784
// radio_awake_status is the only input-only line
`define FIXED_IN_MASK 40'h00_0000_0800
`define IRQ_LINE_A 32
`define IRQ_LINE_B 37
`define ADC_FIRST_CH 3
`define ADC_BITS 12
`define EDGE_RISE_BIT 0
`define EDGE_FALL_BIT 1

// ----------------------------------------------------------------
// two-wire target
// ----------------------------------------------------------------
`define TARGET_ADDR 7'h6e

`endif

// *** sync_filter.v ***
// three-stage synchroniser with agreement filter and edge pulses
// assumes asynchronous inputs; outputs all come from flip-flops
`timescale 1ns/1ps
`default_nettype none

module sync_filter #(
  parameter W = 1
) (
  input wire clk,
  input wire rst,
  input wire [W-1:0] d,
  output reg [W-1:0] q_q,
  output reg [W-1:0] rise_q,
  output reg [W-1:0] fall_q
);

  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;
  wire [W-1:0] q_d;

  // a level is taken only once stages two and three agree
  assign q_d = (s2_q & s3_q) | (q_q & (s2_q | s3_q));

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
      s3_q <= {W{1'b0}};
      q_q <= {W{1'b0}};
      rise_q <= {W{1'b0}};
      fall_q <= {W{1'b0}};
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      q_q <= q_d;
      rise_q <= q_d & ~q_q;
      fall_q <= ~q_d & q_q;
    end
  end

endmodule

`default_nettype wire

// *** twowire_target.v ***
// two-wire serial target turning bus transfers into register strobes
// assumes filtered line levels and edge pulses from a synchroniser
`timescale 1ns/1ps
`default_nettype none
`include "io_expander_consts.vh"

module twowire_target #(
  parameter [6:0] ADDR = `TARGET_ADDR
) (
  input wire clk,
  input wire rst,
  input wire scl,
  input wire sda,
  input wire scl_rise,
  input wire scl_fall,
  input wire sda_rise,
  input wire sda_fall,
  output wire sda_oe_n,
  output reg [7:0] ptr_q,
  output reg [31:0] wbuf_q,
  output reg wr_q,
  output reg rd_q,
  input wire [31:0] rdata
);

  localparam [2:0] S_IDLE = 3'd0;
  localparam [2:0] S_ADDR = 3'd1;
  localparam [2:0] S_ACKA = 3'd2;
  localparam [2:0] S_WR = 3'd3;
  localparam [2:0] S_ACKW = 3'd4;
  localparam [2:0] S_RD = 3'd5;
  localparam [2:0] S_ACKR = 3'd6;

  reg [2:0] st_q;
  reg [7:0] sh_q;
  reg [3:0] bit_q;
  reg rw_q;
  reg first_q;
  reg [1:0] lane_q;
  reg [31:0] rbuf_q;
  reg load_q;
  reg drv_q;
  wire [7:0] rbyte;

  assign rbyte = rbuf_q[{lane_q, 3'b000} +: 8];
  // open drain: the enable is low only while pulling the line low
  assign sda_oe_n = ~drv_q;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= S_IDLE;
      sh_q <= 8'h00;
      bit_q <= 4'h0;
      rw_q <= 1'b0;
      first_q <= 1'b0;
      lane_q <= 2'h0;
      rbuf_q <= 32'h0000_0000;
      load_q <= 1'b0;
      drv_q <= 1'b0;
      ptr_q <= 8'h00;
      wbuf_q <= 32'h0000_0000;
      wr_q <= 1'b0;
      rd_q <= 1'b0;
    end else begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      load_q <= rd_q;
      // step the pointer only once the committed word has used it
      if (wr_q) begin
        ptr_q <= ptr_q + 8'h04;
      end
      if (load_q) begin
        rbuf_q <= rdata;
      end
      if (sda_fall && scl) begin
        st_q <= S_ADDR;
        bit_q <= 4'h0;
        drv_q <= 1'b0;
      end else if (sda_rise && scl) begin
        st_q <= S_IDLE;
        drv_q <= 1'b0;
      end else if (scl_rise) begin
        if (st_q == S_ADDR || st_q == S_WR) begin
          sh_q <= {sh_q[6:0], sda};
          bit_q <= bit_q + 4'h1;
        end else if (st_q == S_ACKR) begin
          if (sda) begin
            st_q <= S_IDLE;
          end else begin
            lane_q <= lane_q + 2'h1;
            if (lane_q == 2'h3) begin
              ptr_q <= ptr_q + 8'h04;
              rd_q <= 1'b1;
            end
          end
        end
      end else if (scl_fall) begin
        case (st_q)
          S_ADDR: begin
            if (bit_q == 4'h8) begin
              if (sh_q[7:1] == ADDR) begin
                drv_q <= 1'b1;
                rw_q <= sh_q[0];
                first_q <= ~sh_q[0];
                lane_q <= 2'h0;
                rd_q <= sh_q[0];
                st_q <= S_ACKA;
              end else begin
                st_q <= S_IDLE;
              end
            end
          end
          S_ACKA: begin
            bit_q <= 4'h0;
            st_q <= rw_q ? S_RD : S_WR;
            drv_q <= rw_q & ~rbyte[7];
          end
          S_WR: begin
            if (bit_q == 4'h8) begin
              drv_q <= 1'b1;
              st_q <= S_ACKW;
              if (first_q) begin
                ptr_q <= sh_q;
                first_q <= 1'b0;
              end else begin
                wbuf_q[{lane_q, 3'b000} +: 8] <= sh_q;
                lane_q <= lane_q + 2'h1;
                wr_q <= (lane_q == 2'h3);
              end
            end
          end
          S_ACKW: begin
            drv_q <= 1'b0;
            bit_q <= 4'h0;
            st_q <= S_WR;
          end
          S_RD: begin
            bit_q <= bit_q + 4'h1;
            if (bit_q == 4'h7) begin
              drv_q <= 1'b0;
              st_q <= S_ACKR;
            end else begin
              drv_q <= ~rbyte[3'd6 - bit_q[2:0]];
            end
          end
          S_ACKR: begin
            bit_q <= 4'h0;
            st_q <= S_RD;
            drv_q <= ~rbyte[7];
          end
          default: begin
            st_q <= S_IDLE;
          end
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// *** io_expander_monitor.sv ***
// port checker for the line expander
// assumes the header constants and one clock with async high reset
`timescale 1ns/1ps
`default_nettype none
`include "io_expander_consts.vh"

module io_expander_monitor #(
  parameter NLINES = 40,
  parameter NADC = 3
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic scl_in,
  input wire logic sda_oe_n,
  input wire logic [NLINES-1:0] line_in,
  input wire logic [NLINES-1:0] line_out,
  input wire logic [NLINES-1:0] line_oe_n,
  input wire logic irq,
  input wire logic wake_req,
  input wire logic micro_attention_irq_n,
  input wire logic cpu_attention_irq_n
);
  // ----------------------------------------
  // cycles since an interrupt pin moved
  // ----------------------------------------
  logic [1:0] pin_q;
  logic [3:0] age_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_q <= 2'b00;
      age_q <= 4'hf;
    end else begin
      pin_q <= {line_in[37], line_in[32]};
      if (pin_q != {line_in[37], line_in[32]}) begin
        age_q <= 4'h0;
      end else if (age_q != 4'hf) begin
        age_q <= age_q + 4'h1;
      end
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_attn;
    micro_attention_irq_n == !irq && cpu_attention_irq_n == !irq;
  endproperty
  a_attn: assert property (p_attn) else $error("attention level wrong");
  property p_wake;
    wake_req == irq;
  endproperty
  a_wake: assert property (p_wake) else $error("wake differs from irq");
  // synchroniser adds about five cycles; eight leaves margin
  property p_cause;
    $rose(irq) |-> age_q < 4'h8 || $past(reg_wr);
  endproperty
  a_cause: assert property (p_cause) else $error("irq without cause");
  property p_fixed;
    (line_oe_n & `FIXED_OUT_MASK) == 40'h0;
  endproperty
  a_fixed: assert property (p_fixed) else $error("rail line undriven");
  property p_radio_in;
    line_oe_n[11];
  endproperty
  a_radio_in: assert property (p_radio_in) else $error("status driven");
  property p_cam;
    reg_wr && reg_addr == `OFS_DIR_LO |=> line_oe_n[31] == !$past(reg_wdata[31]);
  endproperty
  a_cam: assert property (p_cam) else $error("line 31 drive wrong");
  property p_led;
    reg_wr && reg_addr == `OFS_OUT_LO |=> line_out[23] == $past(reg_wdata[23]);
  endproperty
  a_led: assert property (p_led) else $error("indicator level wrong");
  property p_adc;
    reg_rd && reg_addr >= 8'h4c && reg_addr <= 8'h54 |=> reg_rdata[31:12] == 20'h0;
  endproperty
  a_adc: assert property (p_adc) else $error("result not justified");
  property p_sda;
    !$stable(sda_oe_n) |-> !scl_in;
  endproperty
  a_sda: assert property (p_sda) else $error("sda moved, scl high");
  property p_ack;
    $fell(sda_oe_n) |-> !sda_oe_n [*8];
  endproperty
  a_ack: assert property (p_ack) else $error("ack too short");
endmodule

bind board_io_expander io_expander_monitor #(
  .NLINES(NLINES),
  .NADC(NADC)
) i_io_expander_monitor (
  .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .scl_in(scl_in), .sda_oe_n(sda_oe_n), .line_in(line_in),
  .line_out(line_out), .line_oe_n(line_oe_n), .irq(irq),
  .wake_req(wake_req), .micro_attention_irq_n(micro_attention_irq_n),
  .cpu_attention_irq_n(cpu_attention_irq_n)
);
`default_nettype wire

// *** twowire_host.sv ***
// host side of the two-wire bus: start, stop, byte out, byte in
// assumes a pull-up on sda; scl is only ever driven by this host
`timescale 1ns/1ps
`default_nettype none

module twowire_host #(
  parameter QTR = 10
) (
  input wire logic clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_drv
);
  // releasing sda hands it to the pull-up, so idle reads high
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic pause(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic start_cond();
    sda_drv <= 1'b0;
    pause(QTR);
    scl <= 1'b0;
    pause(QTR);
  endtask
  task automatic stop_cond();
    sda_drv <= 1'b0;
    pause(QTR);
    scl <= 1'b1;
    pause(QTR);
    sda_drv <= 1'b1;
    pause(2 * QTR);
  endtask
  // data only moves while scl is low
  task automatic put_bit(input logic b);
    sda_drv <= b;
    pause(QTR);
    scl <= 1'b1;
    pause(2 * QTR);
    scl <= 1'b0;
    pause(QTR);
  endtask
  task automatic get_bit(output logic b);
    sda_drv <= 1'b1;
    pause(QTR);
    scl <= 1'b1;
    pause(QTR);
    #1 b = sda_line;
    pause(QTR);
    scl <= 1'b0;
    pause(QTR);
  endtask
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(a);
    ack = !a;
  endtask
  task automatic get_byte(output logic [7:0] d, input logic ack);
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    put_bit(!ack);
  endtask
endmodule
`default_nettype wire

// *** test_board_io_expander.sv ***
// self-checking bench for the line expander
// assumes the two-wire host model and the bound port checker
`timescale 1ns/1ps
`default_nettype none
`include "io_expander_consts.vh"

module test_board_io_expander;
  logic clk;
  logic rst;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic [39:0] line_in;
  logic [35:0] adc_code;
  logic [2:0] adc_valid;
  wire logic [31:0] reg_rdata;
  wire logic [39:0] line_out;
  wire logic [39:0] line_oe_n;
  wire logic sda_out, sda_oe_n, irq, wake_req, scl, sda_drv, sda_bus;
  wire logic micro_attention_irq_n;
  wire logic cpu_attention_irq_n;
  int error_cnt;
  int tests_run;

  // open-drain bus with pull-up
  assign sda_bus = sda_drv & (sda_oe_n | sda_out);

  board_io_expander i_board_io_expander (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .scl_in(scl), .sda_in(sda_bus), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .line_in(line_in), .line_out(line_out),
    .line_oe_n(line_oe_n), .adc_code(adc_code), .adc_valid(adc_valid),
    .irq(irq), .wake_req(wake_req),
    .micro_attention_irq_n(micro_attention_irq_n),
    .cpu_attention_irq_n(cpu_attention_irq_n)
  );
  twowire_host #(.QTR(10)) i_twowire_host (
    .clk(clk), .sda_line(sda_bus), .scl(scl), .sda_drv(sda_drv)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic test_done();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(string nm, logic [39:0] seen, logic [39:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic rd_chk(string nm, logic [7:0] a, logic [31:0] exp);
    logic [31:0] d;
    rd(a, d);
    check(nm, d, exp);
  endtask
  // host watches only the micro line; status settles within a few cycles
  task automatic wait_attn(input logic exp);
    for (int i = 0; i < 12; i++) begin
      @(posedge clk);
      if (exp && micro_attention_irq_n === 1'b0) break;
    end
    #1 check("attn_micro", micro_attention_irq_n, !exp);
    check("attn_cpu", cpu_attention_irq_n, !exp);
    check("wake", wake_req, exp);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    check("oe_reset", line_oe_n, ~`FIXED_OUT_MASK);
    check("out_reset", line_out, 40'h0);
    check("attn_reset", micro_attention_irq_n, 1'b1);
    check("sda_reset", sda_oe_n, 1'b1);
    rd_chk("dir_lo", `OFS_DIR_LO, `FIXED_OUT_MASK);
    rd_chk("unmapped", 8'h30, 32'h0);
  endtask
  task automatic t_lines();
    logic [31:0] d;
    wr(`OFS_DIR_LO, 32'hffff_ffff);
    wr(`OFS_DIR_HI, 32'h0000_00ff);
    wr(`OFS_OUT_LO, 32'ha5c3_5a3c);
    wr(`OFS_OUT_HI, 32'h0000_0096);
    check("oe_out", line_oe_n, `FIXED_IN_MASK);
    check("lvl", line_out & ~`FIXED_IN_MASK, 40'h96_a5c3_523c);
    check("indicator", line_out[23], 1'b1);
    wr(`OFS_DIR_LO, 32'h0);
    wr(`OFS_DIR_HI, 32'h0);
    check("oe_in", line_oe_n, ~`FIXED_OUT_MASK);
    line_in <= 40'h5a_bc96_e1d2;
    repeat (4) @(posedge clk);
    rd(`OFS_IN_LO, d);
    check("in_lo", d & ~`FIXED_OUT_MASK, 32'h8090_0052);
    rd(`OFS_IN_HI, d);
    check("in_hi", d[7:0] & 8'hb9, 8'h18);
    line_in <= 40'h0;
    repeat (4) @(posedge clk);
  endtask
  task automatic t_edges();
    int ln;
    for (int s = 0; s < 2; s++) begin
      ln = s ? `IRQ_LINE_B : `IRQ_LINE_A;
      for (int e = 0; e < 4; e++) begin
        wr(`OFS_IRQ_MASK, 32'h1 << s);
        wr(`OFS_IRQ_EDGE, e << (2 * s));
        wr(`OFS_IRQ_STAT, 32'h3);
        line_in[ln] <= 1'b1;
        wait_attn(e[0]);
        rd_chk("stat_rise", `OFS_IRQ_STAT, {31'h0, e[0]} << s);
        wr(`OFS_IRQ_STAT, 32'h3);
        wait_attn(1'b0);
        line_in[ln] <= 1'b0;
        wait_attn(e[1]);
        rd_chk("stat_fall", `OFS_IRQ_STAT, {31'h0, e[1]} << s);
        wr(`OFS_IRQ_STAT, 32'h3);
      end
    end
  endtask
  // masked sources still record status, but must not wake the host
  task automatic t_mask();
    wr(`OFS_IRQ_MASK, 32'h0);
    wr(`OFS_IRQ_EDGE, 32'h3);
    line_in[`IRQ_LINE_A] <= 1'b1;
    wait_attn(1'b0);
    rd_chk("stat_masked", `OFS_IRQ_STAT, 32'h1);
    wr(`OFS_IRQ_MASK, 32'h1);
    check("unmasked", micro_attention_irq_n, 1'b0);
    wr(`OFS_IRQ_STAT, 32'h1);
    check("cleared", wake_req, 1'b0);
    line_in[`IRQ_LINE_A] <= 1'b0;
    wait_attn(1'b1);
    wr(`OFS_IRQ_EDGE, 32'h0);
    wr(`OFS_IRQ_STAT, 32'h3);
  endtask
  task automatic t_adc();
    wr(`OFS_DIR_LO, 32'h38);
    wr(`OFS_ADC_MODE, 32'h7);
    check("adc_release", line_oe_n[5:3], 3'b111);
    adc_code <= {12'h800, 12'h001, 12'hfff};
    adc_valid <= 3'b111;
    @(posedge clk);
    adc_valid <= 3'b000;
    rd_chk("adc3", 8'h4c, 32'h0000_0fff);
    rd_chk("adc4", 8'h50, 32'h0000_0001);
    rd_chk("adc5", 8'h54, 32'h0000_0800);
    wr(`OFS_ADC_MODE, 32'h0);
    check("adc_digital", line_oe_n[5:3], 3'b000);
    wr(`OFS_DIR_LO, 32'h0);
  endtask
  task automatic t_bus();
    logic a;
    logic [7:0] b;
    logic [31:0] w;
    i_twowire_host.start_cond();
    i_twowire_host.put_byte(8'h40, a);
    check("ack_other", a, 1'b0);
    i_twowire_host.stop_cond();
    i_twowire_host.start_cond();
    i_twowire_host.put_byte({`TARGET_ADDR, 1'b0}, a);
    check("ack_addr", a, 1'b1);
    i_twowire_host.put_byte(`OFS_OUT_LO, a);
    for (int i = 0; i < 4; i++) begin
      w = 32'h4433_2211;
      i_twowire_host.put_byte(w[8*i +: 8], a);
      check("ack_data", a, 1'b1);
    end
    i_twowire_host.stop_cond();
    check("bus_write", line_out[31:0], 32'h4433_2211);
    i_twowire_host.start_cond();
    i_twowire_host.put_byte({`TARGET_ADDR, 1'b0}, a);
    i_twowire_host.put_byte(`OFS_OUT_LO, a);
    i_twowire_host.stop_cond();
    i_twowire_host.start_cond();
    i_twowire_host.put_byte({`TARGET_ADDR, 1'b1}, a);
    for (int i = 0; i < 4; i++) begin
      i_twowire_host.get_byte(b, i < 3);
      w[8*i +: 8] = b;
    end
    i_twowire_host.stop_cond();
    check("bus_read", w, 32'h4433_2211);
  endtask

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    error_cnt = 0;
    tests_run = 0;
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h0;
    reg_wdata = 32'h0;
    line_in = 40'h0;
    adc_code = 36'h0;
    adc_valid = 3'h0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    t_reset();
    t_lines();
    t_edges();
    t_mask();
    t_adc();
    t_bus();
    test_done();
  end
  initial begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    test_done();
  end
endmodule
`default_nettype wire
